// file: src/gbt_pkg.sv
// Purpose: Shared constants for the blanking and turn-off configuration bank.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Register words are 16 bits; bit 1 flags the last message, bit 0 is odd parity.
package gbt_pkg;
  localparam logic [7:0]  GBT_OFS_OVERCURRENT_BLANKING = 8'h19;
  localparam logic [7:0]  GBT_OFS_REGULAR_TURNOFF      = 8'h1a;
  localparam logic [7:0]  GBT_OFS_SAFE_TURNOFF         = 8'h1b;
  localparam logic [15:0] GBT_RST_OVERCURRENT_BLANKING = 16'h0001;
  localparam logic [15:0] GBT_RST_REGULAR_TURNOFF      = 16'h0001;
  localparam logic [15:0] GBT_RST_SAFE_TURNOFF         = 16'h2000;
  localparam int          GBT_COUNT_HI                 = 15;
  localparam int          GBT_COUNT_LO                 = 8;
  localparam int          GBT_LEVEL_HI                 = 7;
  localparam int          GBT_LEVEL_LO                 = 4;
  localparam int          GBT_LMI_BIT                  = 1;
  localparam int          GBT_PARITY_BIT               = 0;
  localparam logic [7:0]  GBT_BLANK_MAX                = 8'h2f;
  localparam logic [7:0]  GBT_REGULAR_MIN              = 8'h02;
  localparam logic [7:0]  GBT_SAFE_MIN                 = 8'h0a;
  // Host controller register offsets, interrupt bit positions and the mode four code.
  localparam logic [3:0]  GBT_HOST_CMD                 = 4'h0;
  localparam logic [3:0]  GBT_HOST_RDATA               = 4'h1;
  localparam logic [3:0]  GBT_HOST_STATUS              = 4'h2;
  localparam logic [3:0]  GBT_HOST_IRQ_STATUS          = 4'h3;
  localparam logic [3:0]  GBT_HOST_IRQ_MASK            = 4'h4;
  localparam logic [3:0]  GBT_HOST_MODE                = 4'h5;
  localparam logic [3:0]  GBT_HOST_REGULAR_LEVEL       = 4'h6;
  localparam int          GBT_IRQ_DONE_BIT             = 0;
  localparam int          GBT_IRQ_REFUSED_BIT          = 1;
  localparam int          GBT_IRQ_INVALID_BIT          = 2;
  localparam logic [2:0]  GBT_MODE_FOUR                = 3'h4;
endpackage : gbt_pkg

// file: src/gbt_link_if.sv
// Purpose: Register message link between host controller and configuration bank.
// Assumes: One clock; a request is a one-cycle strobe, the answer stands the next cycle.
// Notes:   No clocking block.
`timescale 1ns/1ps
`default_nettype none
interface gbt_link_if;
  logic        req;
  logic        wr;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        rvalid;
  logic [15:0] rdata;
  modport device (input req, input wr, input addr, input wdata, output rvalid, output rdata);
  modport host   (output req, output wr, output addr, output wdata, input rvalid, input rdata);
endinterface : gbt_link_if
`default_nettype wire

// file: src/gbt_parity_word.sv
// Purpose: Inserts the message flag and the odd-parity bit into a register word.
// Assumes: Upper 14 bits already hold the register contents.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module gbt_parity_word
  import gbt_pkg::*;
(
  input  wire logic [15:0] body_in,
  input  wire logic        invalid_in,
  output logic [15:0]      word_out
);
  always_comb begin
    word_out                 = body_in;
    word_out[GBT_LMI_BIT]    = invalid_in;
    word_out[GBT_PARITY_BIT] = 1'b0;
    word_out[GBT_PARITY_BIT] = ~(^word_out);
  end
endmodule : gbt_parity_word
`default_nettype wire

// file: src/gbt_device.sv
// Purpose: Configuration bank for overcurrent blanking and two-level turn-off.
// Assumes: Host keeps the field limits; writes take one cycle, reads answer one cycle later.
// Notes:   Unknown offsets are discarded and flagged in the word returned by the next message, if that message is a read.
// Notes on behaviour
// - Blanking count from bits 15:8, oscillator cycles.
// - Zero blanking count disables blanking generation.
// - Host keeps blanking count at most 2F.
// - Bit 1 flags last message discarded.
// - Bit 0 makes every word odd parity.
// - Regular turn-off delay from bits 15:8.
// - Zero regular delay skips two-level turn-off.
// - Host programs regular delay at least 2.
// - Safe delay bits 15:8; zero disables it.
// - Host programs safe delay at least A.
// - Host should zero safe delay, modes five/six; host does not check it.
// - Mode four: safe delay above regular delay.
// - Safe plateau level bits 7:4, same coding.
// - Mode four: safe level not above regular.
`timescale 1ns/1ps
`default_nettype none
module gbt_device
  import gbt_pkg::*;
(
  input  wire logic   sys_clk_in,
  input  wire logic   rst_n_in,
  gbt_link_if.device  link,
  output logic [7:0]  overcurrent_blank_count_out,
  output logic        overcurrent_blank_enable_out,
  output logic [7:0]  regular_turnoff_delay_count_out,
  output logic        regular_two_level_enable_out,
  output logic [7:0]  safe_turnoff_delay_count_out,
  output logic        safe_two_level_enable_out,
  output logic [3:0]  safe_turnoff_plateau_level_out
);
  typedef struct packed {
    logic [7:0]  blank;
    logic [7:0]  regular;
    logic [7:0]  safe;
    logic [3:0]  level;
    logic        invalid;
    logic        rvalid;
    logic [15:0] rdata;
  } gbt_dev_state_t;

  gbt_dev_state_t state_reg;
  gbt_dev_state_t state_next;
  logic [15:0]    body;
  logic [15:0]    word;
  logic           known;

  always_comb begin
    known = 1'b1;
    case (link.addr)
      GBT_OFS_OVERCURRENT_BLANKING: body = {state_reg.blank, 8'h00};
      GBT_OFS_REGULAR_TURNOFF:      body = {state_reg.regular, 8'h00};
      GBT_OFS_SAFE_TURNOFF:         body = {state_reg.safe, state_reg.level, 4'h0};
      default: begin
        body  = 16'h0000;
        known = 1'b0;
      end
    endcase
  end

  gbt_parity_word u_parity (
    .body_in    (body),
    .invalid_in (state_reg.invalid),
    .word_out   (word)
  );

  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = 1'b0;
    if (link.req) begin
      state_next.invalid = ~known;
      if (!link.wr) begin
        state_next.rvalid = 1'b1;
        state_next.rdata  = word;
      end else if (known) begin
        case (link.addr)
          GBT_OFS_OVERCURRENT_BLANKING: state_next.blank = link.wdata[GBT_COUNT_HI:GBT_COUNT_LO];
          GBT_OFS_REGULAR_TURNOFF:      state_next.regular = link.wdata[GBT_COUNT_HI:GBT_COUNT_LO];
          GBT_OFS_SAFE_TURNOFF: begin
            state_next.safe  = link.wdata[GBT_COUNT_HI:GBT_COUNT_LO];
            state_next.level = link.wdata[GBT_LEVEL_HI:GBT_LEVEL_LO];
          end
          default: state_next.invalid = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_reg.blank   <= GBT_RST_OVERCURRENT_BLANKING[GBT_COUNT_HI:GBT_COUNT_LO];
      state_reg.regular <= GBT_RST_REGULAR_TURNOFF[GBT_COUNT_HI:GBT_COUNT_LO];
      state_reg.safe    <= GBT_RST_SAFE_TURNOFF[GBT_COUNT_HI:GBT_COUNT_LO];
      state_reg.level   <= GBT_RST_SAFE_TURNOFF[GBT_LEVEL_HI:GBT_LEVEL_LO];
      state_reg.invalid <= 1'b0;
      state_reg.rvalid  <= 1'b0;
      state_reg.rdata   <= 16'h0000;
    end else begin
      state_reg <= state_next;
    end
  end

  logic [7:0] blank_q;
  logic [7:0] regular_q;
  logic [7:0] safe_q;
  logic [3:0] level_q;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      blank_q   <= GBT_RST_OVERCURRENT_BLANKING[GBT_COUNT_HI:GBT_COUNT_LO];
      regular_q <= GBT_RST_REGULAR_TURNOFF[GBT_COUNT_HI:GBT_COUNT_LO];
      safe_q    <= GBT_RST_SAFE_TURNOFF[GBT_COUNT_HI:GBT_COUNT_LO];
      level_q   <= GBT_RST_SAFE_TURNOFF[GBT_LEVEL_HI:GBT_LEVEL_LO];
      overcurrent_blank_enable_out <= (GBT_RST_OVERCURRENT_BLANKING[GBT_COUNT_HI:GBT_COUNT_LO] != 8'h00);
      regular_two_level_enable_out <= (GBT_RST_REGULAR_TURNOFF[GBT_COUNT_HI:GBT_COUNT_LO] != 8'h00);
      safe_two_level_enable_out    <= (GBT_RST_SAFE_TURNOFF[GBT_COUNT_HI:GBT_COUNT_LO] != 8'h00);
    end else begin
      blank_q   <= state_next.blank;
      regular_q <= state_next.regular;
      safe_q    <= state_next.safe;
      level_q   <= state_next.level;
      overcurrent_blank_enable_out <= (state_next.blank != 8'h00);
      regular_two_level_enable_out <= (state_next.regular != 8'h00);
      safe_two_level_enable_out    <= (state_next.safe != 8'h00);
    end
  end

  assign overcurrent_blank_count_out     = blank_q;
  assign regular_turnoff_delay_count_out = regular_q;
  assign safe_turnoff_delay_count_out    = safe_q;
  assign safe_turnoff_plateau_level_out  = level_q;
  assign link.rvalid                     = state_reg.rvalid;
  assign link.rdata                      = state_reg.rdata;
endmodule : gbt_device
`default_nettype wire

// file: src/gbt_host.sv
// Purpose: Host controller issuing register messages and checking field limits.
// Assumes: Software port: one-cycle strobes, read data one cycle later.
// Notes:   Writes that break a field limit are refused and raise an interrupt.
`timescale 1ns/1ps
`default_nettype none
module gbt_host
  import gbt_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [3:0]  sw_addr_in,
  input  wire logic [31:0] sw_wdata_in,
  input  wire logic        sw_wr_in,
  input  wire logic        sw_rd_in,
  output logic [31:0]      sw_rdata_out,
  output logic             irq_out,
  gbt_link_if.host         link
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_WAIT = 3'b100
  } gbt_host_st_t;

  typedef struct packed {
    gbt_host_st_t fsm;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [2:0]  mode;
    logic [3:0]  reg_level;
    logic [7:0]  sh_regular;
    logic [31:0] sw_rdata;
    logic        irq;
  } gbt_host_state_t;

  gbt_host_state_t s_reg;
  gbt_host_state_t s_next;
  logic [7:0]      cnt;
  logic [3:0]      lvl;
  logic            ok;
  logic [2:0]      ev;

  always_comb begin
    cnt = sw_wdata_in[GBT_COUNT_HI:GBT_COUNT_LO];
    lvl = sw_wdata_in[GBT_LEVEL_HI:GBT_LEVEL_LO];
    ok  = 1'b1;
    case (sw_wdata_in[23:16])
      GBT_OFS_OVERCURRENT_BLANKING: ok = (cnt <= GBT_BLANK_MAX);
      GBT_OFS_REGULAR_TURNOFF:      ok = (cnt == 8'h00) || (cnt >= GBT_REGULAR_MIN);
      GBT_OFS_SAFE_TURNOFF: begin
        ok = (cnt == 8'h00) || (cnt >= GBT_SAFE_MIN);
        if (s_reg.mode == GBT_MODE_FOUR && cnt != 8'h00) begin
          ok = ok && (cnt > s_reg.sh_regular) && (lvl <= s_reg.reg_level);
        end
      end
      default: ok = 1'b1;
    endcase
  end

  always_comb begin
    s_next          = s_reg;
    s_next.sw_rdata = 32'h0000_0000;
    ev              = 3'b000;
    case (s_reg.fsm)
      ST_IDLE: ;
      ST_SEND: s_next.fsm = s_reg.wr ? ST_IDLE : ST_WAIT;
      ST_WAIT: begin
        if (link.rvalid) begin
          s_next.rdata = link.rdata;
          s_next.fsm   = ST_IDLE;
          ev[GBT_IRQ_INVALID_BIT] = link.rdata[GBT_LMI_BIT];
        end
      end
      default: s_next.fsm = ST_IDLE;
    endcase
    if (s_reg.fsm == ST_SEND && s_reg.wr) begin
      ev[GBT_IRQ_DONE_BIT] = 1'b1;
    end
    if (s_reg.fsm == ST_WAIT && link.rvalid) begin
      ev[GBT_IRQ_DONE_BIT] = 1'b1;
    end
    if (sw_wr_in) begin
      case (sw_addr_in)
        GBT_HOST_CMD: begin
          if (s_reg.fsm == ST_IDLE && (ok || !sw_wdata_in[24])) begin
            s_next.fsm   = ST_SEND;
            s_next.wr    = sw_wdata_in[24];
            s_next.addr  = sw_wdata_in[23:16];
            s_next.wdata = sw_wdata_in[15:0];
            if (sw_wdata_in[24] && sw_wdata_in[23:16] == GBT_OFS_REGULAR_TURNOFF) begin
              s_next.sh_regular = cnt;
            end
          end else begin
            ev[GBT_IRQ_REFUSED_BIT] = 1'b1;
          end
        end
        GBT_HOST_IRQ_STATUS:    s_next.irq_status = s_reg.irq_status & ~sw_wdata_in[2:0];
        GBT_HOST_IRQ_MASK:      s_next.irq_mask = sw_wdata_in[2:0];
        GBT_HOST_MODE:          s_next.mode = sw_wdata_in[2:0];
        GBT_HOST_REGULAR_LEVEL: s_next.reg_level = sw_wdata_in[3:0];
        default: ;
      endcase
    end
    s_next.irq_status = s_next.irq_status | ev;
    s_next.irq        = |(s_next.irq_status & s_next.irq_mask);
    if (sw_rd_in) begin
      case (sw_addr_in)
        GBT_HOST_RDATA:         s_next.sw_rdata = {16'h0000, s_reg.rdata};
        GBT_HOST_STATUS:        s_next.sw_rdata = {31'h0000_0000, s_reg.fsm != ST_IDLE};
        GBT_HOST_IRQ_STATUS:    s_next.sw_rdata = {29'h0000_0000, s_reg.irq_status};
        GBT_HOST_IRQ_MASK:      s_next.sw_rdata = {29'h0000_0000, s_reg.irq_mask};
        GBT_HOST_MODE:          s_next.sw_rdata = {29'h0000_0000, s_reg.mode};
        GBT_HOST_REGULAR_LEVEL: s_next.sw_rdata = {28'h0000_0000, s_reg.reg_level};
        default:                s_next.sw_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_reg            <= '0;
      s_reg.fsm        <= ST_IDLE;
      s_reg.sh_regular <= GBT_RST_REGULAR_TURNOFF[GBT_COUNT_HI:GBT_COUNT_LO];
    end else begin
      s_reg <= s_next;
    end
  end

  assign sw_rdata_out = s_reg.sw_rdata;
  assign irq_out      = s_reg.irq;
  assign link.req     = (s_reg.fsm == ST_SEND);
  assign link.wr      = s_reg.wr;
  assign link.addr    = s_reg.addr;
  assign link.wdata   = s_reg.wdata;
endmodule : gbt_host
`default_nettype wire

// file: bench/gbt_link_chk.sv
// Purpose: Link checker for the blanking and turn-off bank.
// Assumes: One clock, synchronous active-low reset.
// Notes: Sees only the link signals.
`timescale 1ns/1ps
`default_nettype none
module gbt_link_chk (
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        rvalid,
  input wire logic [15:0] rdata
);
  logic       bad_reg;
  logic [7:0] blank_reg;
  wire logic  known = addr inside {8'h19, 8'h1a, 8'h1b};
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      bad_reg   <= 1'b0;
      blank_reg <= 8'h00;
    end else begin
      if (req) bad_reg <= !known;
      if (req && wr && addr == 8'h19) blank_reg <= wdata[15:8];
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_rd(logic [7:0] a);
    req && !wr && addr == a;
  endsequence
  a_read_answer: assert property (req && !wr |=> rvalid) else $error("read not answered");
  a_odd_parity: assert property (rvalid |-> ^rdata) else $error("word not odd parity");
  a_blank_value: assert property (s_rd(8'h19) |=> rdata[15:8] == blank_reg) else $error("blank count");
  a_blank_rsvd: assert property (s_rd(8'h19) |=> rdata[7:2] == 6'h00) else $error("reserved bits");
  a_regular_rsvd: assert property (s_rd(8'h1a) |=> rdata[7:2] == 6'h00) else $error("reserved bits");
  a_safe_rsvd: assert property (s_rd(8'h1b) |=> rdata[3:2] == 2'h0) else $error("reserved bits");
  a_flag_set: assert property (req && !wr && bad_reg |=> rdata[1]) else $error("flag not set");
  a_flag_clear: assert property (req && !wr && !bad_reg |=> !rdata[1]) else $error("flag set");
  a_unknown_zero: assert property (req && !wr && !known |=> rdata[15:2] == 14'h0000) else $error("body");
endmodule // gbt_link_chk
`default_nettype wire

// file: bench/tb.sv
// Purpose: Self-checking bench for host and bank joined by the link.
// Assumes: 200 MHz clock, synchronous active-low reset.
// Notes: Expected words come from a shadow of accepted writes.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gbt_pkg::*;
  logic        sys_clk_in, rst_n_in, sw_wr_in, sw_rd_in, irq_out, b_en, r_en, s_en;
  logic [3:0]  sw_addr_in, lvl;
  logic [31:0] sw_wdata_in, sw_rdata_out, st, rd;
  logic [7:0]  b_cnt, r_cnt, s_cnt;
  logic [15:0] sh [3];
  logic [7:0]  t_ofs [13] = '{8'h19, 8'h19, 8'h19, 8'h1a, 8'h1a, 8'h1a, 8'h1b, 8'h1b, 8'h1b, 8'h1a, 8'h1b,
                               8'h1b, 8'h1b};
  logic [15:0] t_dat [13] = '{16'h2fff, 16'h3000, 16'h0000, 16'h01ff, 16'h02ff, 16'h0000, 16'h09f0,
                               16'h0a5f, 16'h0000, 16'h1000, 16'h1030, 16'h1140, 16'h1130};
  logic [12:0] t_ref = 13'h0c4a;
  int          n_errors = 0;
  int          check_count = 0;
  gbt_link_if link_if ();
  gbt_device i_gbt_device (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .link(link_if.device),
    .overcurrent_blank_count_out(b_cnt), .overcurrent_blank_enable_out(b_en),
    .regular_turnoff_delay_count_out(r_cnt), .regular_two_level_enable_out(r_en),
    .safe_turnoff_delay_count_out(s_cnt), .safe_two_level_enable_out(s_en),
    .safe_turnoff_plateau_level_out(lvl));
  gbt_host i_gbt_host (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sw_addr_in(sw_addr_in),
    .sw_wdata_in(sw_wdata_in), .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out),
    .irq_out(irq_out), .link(link_if.host));
  gbt_link_chk i_gbt_link_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .req(link_if.req),
    .wr(link_if.wr), .addr(link_if.addr), .wdata(link_if.wdata), .rvalid(link_if.rvalid),
    .rdata(link_if.rdata));
  function automatic logic [15:0] odd(input logic [15:0] b);
    return {b[15:1], ~^b[15:1]};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    sw_addr_in  <= a;
    sw_wdata_in <= d;
    sw_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    sw_wr_in <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    sw_addr_in <= a;
    sw_rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    sw_rd_in <= 1'b0;
    #1;
    d = sw_rdata_out;
  endtask
  task automatic cmd(input logic w, input logic [7:0] ofs, input logic [15:0] d);
    int n;
    sw_write(GBT_HOST_CMD, {7'h00, w, ofs, d});
    st = 32'h0000_0000;
    for (n = 0; n < 20 && st[1:0] == 2'h0; n++) sw_read(GBT_HOST_IRQ_STATUS, st);
    chk("command end", 32'h0000_0001, {31'h0000_0000, |st[1:0]});
    sw_write(GBT_HOST_IRQ_STATUS, 32'h0000_0007);
  endtask
  task automatic dev_read(input logic [7:0] ofs, input logic [15:0] body);
    cmd(1'b0, ofs, 16'h0000);
    sw_read(GBT_HOST_RDATA, rd);
    chk("register word", {16'h0000, odd(body)}, rd);
  endtask
  task automatic chk_outs();
    chk("config outputs", {1'b0, sh[0][15:8], |sh[0][15:8], sh[1][15:8], |sh[1][15:8], sh[2][15:8],
      |sh[2][15:8], sh[2][7:4]}, {1'b0, b_cnt, b_en, r_cnt, r_en, s_cnt, s_en, lvl});
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  initial begin : watchdog
    repeat (20000) @(posedge sys_clk_in);
    n_errors++;
    end_sim();
  end
  initial begin : main
    int i;
    rst_n_in    = 1'b0;
    sw_wr_in    = 1'b0;
    sw_rd_in    = 1'b0;
    sw_addr_in  = 4'h0;
    sw_wdata_in = 32'h0000_0000;
    sh = '{16'h0000, 16'h0000, 16'h2000};
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    #1;
    chk_outs();
    sw_write(GBT_HOST_IRQ_MASK, 32'h0000_0007);
    for (i = 0; i < 3; i++) dev_read(GBT_OFS_OVERCURRENT_BLANKING + 8'(i), sh[i]);
    for (i = 0; i < 13; i++) begin
      if (i == 9) begin
        sw_write(GBT_HOST_MODE, 32'h0000_0004);
        sw_write(GBT_HOST_REGULAR_LEVEL, 32'h0000_0003);
        sw_read(GBT_HOST_MODE, rd);
        chk("mode", 32'h0000_0004, rd);
      end
      cmd(1'b1, t_ofs[i], t_dat[i]);
      chk("refused", {31'h0000_0000, t_ref[i]}, {31'h0000_0000, st[1]});
      if (!t_ref[i]) sh[t_ofs[i][1:0] - 2'h1] = t_dat[i] & (t_ofs[i] == 8'h1b ? 16'hfff0 : 16'hff00);
      dev_read(t_ofs[i], sh[t_ofs[i][1:0] - 2'h1]);
      chk_outs();
    end
    cmd(1'b1, 8'h1c, 16'hffff);
    dev_read(8'h1c, 16'h0002);
    chk("invalid irq", 32'h0000_0001, {31'h0000_0000, st[2]});
    dev_read(8'h19, sh[0] | 16'h0002);
    dev_read(8'h19, sh[0]);
    chk("invalid irq", 32'h0000_0000, {31'h0000_0000, st[2]});
    chk_outs();
    sw_write(GBT_HOST_IRQ_MASK, 32'h0000_0000);
    sw_write(GBT_HOST_CMD, {7'h00, 1'b0, 8'h1a, 16'h0000});
    sw_read(GBT_HOST_STATUS, rd);
    chk("busy", 32'h0000_0001, rd);
    repeat (8) @(posedge sys_clk_in);
    #1;
    chk("masked irq", 32'h0000_0000, {31'h0000_0000, irq_out});
    sw_read(GBT_HOST_IRQ_STATUS, st);
    chk("done sticky", 32'h0000_0001, {31'h0000_0000, st[0]});
    sw_write(GBT_HOST_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk("unmasked irq", 32'h0000_0001, {31'h0000_0000, irq_out});
    sw_write(GBT_HOST_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk("cleared irq", 32'h0000_0000, {31'h0000_0000, irq_out});
    sw_read(4'hf, rd);
    chk("unmapped read", 32'h0000_0000, rd);
    end_sim();
  end
endmodule // tb
`default_nettype wire
